// ===== status_flags_pkg.sv
// Package: offsets, field positions, reset values and types for the flags register
package status_flags_pkg;

    // Mirror addresses of the register, one per data-memory bank
    localparam logic [8:0] FLAGS_ADDR_BANK0 = 9'h003;
    localparam logic [8:0] FLAGS_ADDR_BANK1 = 9'h083;
    localparam logic [8:0] FLAGS_ADDR_BANK2 = 9'h103;
    localparam logic [8:0] FLAGS_ADDR_BANK3 = 9'h183;
    localparam logic [6:0] FLAGS_ADDR_LOW   = 7'h03;

    // Field positions
    localparam int BIT_IND_BANK  = 7;
    localparam int BIT_DIR_HIGH  = 6;
    localparam int BIT_DIR_LOW   = 5;
    localparam int BIT_TIMEOUT   = 4;
    localparam int BIT_POWERDOWN = 3;
    localparam int BIT_ZERO      = 2;
    localparam int BIT_DIGIT     = 1;
    localparam int BIT_CARRY     = 0;

    // Reset values: bank bits clear, reset-cause flags set, arithmetic flags cleared
    localparam logic [2:0] BANK_RESET  = 3'h0;
    localparam logic       CAUSE_RESET = 1'h1;
    localparam logic [2:0] ARITH_RESET = 3'h0;

    // Instruction classes the execution logic presents
    typedef enum logic [3:0] {
        OP_NONE,
        OP_MOVE,
        OP_LOGIC,
        OP_ADD,
        OP_SUB,
        OP_ROT_RIGHT,
        OP_ROT_LEFT,
        OP_CLEAR,
        OP_SWAP,
        OP_BITOP
    } alu_op_t;

    // One instruction as seen by the register
    typedef struct packed {
        logic       valid;
        alu_op_t    op;
        logic [8:0] dest_addr;
        logic       dest_file;
        logic [7:0] src_a;
        logic [7:0] src_b;
        logic [7:0] wr_data;
    } instr_t;

    // Reset-cause events
    typedef struct packed {
        logic power_up;
        logic wdt_clear;
        logic sleep_entry;
        logic wdt_timeout;
    } cause_evt_t;

endpackage

// ===== cpu_status_flags_register.sv
// Processor status register with ALU flags, reset-cause flags and bank select
////////////////////////////////////////////////////////////////////////////////
module cpu_status_flags_register (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire status_flags_pkg::instr_t    instr,
    input  wire status_flags_pkg::cause_evt_t cause,
    input  wire logic [6:0]                  direct_low_addr,
    input  wire logic [7:0]                  fsr_value,
    output logic [7:0]                       flags_value,
    output logic [7:0]                       alu_result,
    output logic [8:0]                       direct_addr,
    output logic [8:0]                       indirect_addr
);

    logic [7:0] flags_reg,  flags_next;
    logic [7:0] result_reg, result_next;
    logic [8:0] daddr_reg,  daddr_next;
    logic [8:0] iaddr_reg,  iaddr_next;

    // Mirror decode: only the low seven bits matter, any bank hits
    function automatic logic hits_flags(input logic [8:0] a);
        return a[6:0] == status_flags_pkg::FLAGS_ADDR_LOW;
    endfunction

    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic       aff_z, aff_c, aff_dc;
    logic       zf, cf, dcf;
    logic       wr_hit;

    ////////////////////////////////////////////////////////////////////////////
    // ALU result and flag computation
    always_comb begin
        sum9   = 9'h000;
        sum5   = 5'h00;
        res    = instr.src_a;
        aff_z  = 1'b0;
        aff_c  = 1'b0;
        aff_dc = 1'b0;
        cf     = flags_reg[status_flags_pkg::BIT_CARRY];
        dcf    = flags_reg[status_flags_pkg::BIT_DIGIT];
        unique case (instr.op)
            status_flags_pkg::OP_ADD: begin
                sum9   = {1'b0, instr.src_a} + {1'b0, instr.src_b};
                sum5   = {1'b0, instr.src_a[3:0]} + {1'b0, instr.src_b[3:0]};
                res    = sum9[7:0];
                cf     = sum9[8];
                dcf    = sum5[4];
                aff_z  = 1'b1;
                aff_c  = 1'b1;
                aff_dc = 1'b1;
            end
            status_flags_pkg::OP_SUB: begin
                // a - b as a + ~b + 1; carry out is the inverted borrow
                sum9   = {1'b0, instr.src_a} + {1'b0, ~instr.src_b} + 9'h001;
                sum5   = {1'b0, instr.src_a[3:0]} + {1'b0, ~instr.src_b[3:0]} + 5'h01;
                res    = sum9[7:0];
                cf     = sum9[8];
                dcf    = sum5[4];
                aff_z  = 1'b1;
                aff_c  = 1'b1;
                aff_dc = 1'b1;
            end
            status_flags_pkg::OP_LOGIC: begin
                res   = instr.src_b;
                aff_z = 1'b1;
            end
            status_flags_pkg::OP_ROT_RIGHT: begin
                res   = {flags_reg[status_flags_pkg::BIT_CARRY], instr.src_a[7:1]};
                cf    = instr.src_a[0];
                aff_c = 1'b1;
            end
            status_flags_pkg::OP_ROT_LEFT: begin
                res   = {instr.src_a[6:0], flags_reg[status_flags_pkg::BIT_CARRY]};
                cf    = instr.src_a[7];
                aff_c = 1'b1;
            end
            status_flags_pkg::OP_CLEAR: begin
                res   = 8'h00;
                aff_z = 1'b1;
            end
            status_flags_pkg::OP_SWAP: res = {instr.src_a[3:0], instr.src_a[7:4]};
            status_flags_pkg::OP_MOVE: res = instr.src_a;
            status_flags_pkg::OP_BITOP: res = instr.wr_data;
            status_flags_pkg::OP_NONE: res = instr.src_a;
        endcase
        zf = (res == 8'h00);
        if (!instr.valid) begin
            aff_z  = 1'b0;
            aff_c  = 1'b0;
            aff_dc = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next register value: destination write, then flag override
    always_comb begin
        flags_next  = flags_reg;
        result_next = instr.valid ? res : result_reg;
        wr_hit      = instr.valid && instr.dest_file && hits_flags(instr.dest_addr);
        if (wr_hit) begin
            // An op that moves any arithmetic flag keeps all three from the write
            flags_next[7:5] = res[7:5];
            flags_next[4:3] = flags_reg[4:3];
            if (!(aff_z || aff_c || aff_dc)) begin
                flags_next[2:0] = res[2:0];
            end
            if (instr.op == status_flags_pkg::OP_CLEAR) begin
                flags_next[7:5] = status_flags_pkg::BANK_RESET;
            end
        end
        // ALU flags win over the destination write
        if (aff_z) flags_next[status_flags_pkg::BIT_ZERO]  = zf;
        if (aff_c) flags_next[status_flags_pkg::BIT_CARRY] = cf;
        if (aff_dc) flags_next[status_flags_pkg::BIT_DIGIT] = dcf;
        // Reset-cause flags move only on hardware events, never on writes
        if (cause.wdt_timeout) flags_next[status_flags_pkg::BIT_TIMEOUT] = 1'b0;
        if (cause.power_up || cause.wdt_clear || cause.sleep_entry) begin
            flags_next[status_flags_pkg::BIT_TIMEOUT] = 1'b1;
        end
        if (cause.sleep_entry) flags_next[status_flags_pkg::BIT_POWERDOWN] = 1'b0;
        if (cause.power_up || cause.wdt_clear) begin
            flags_next[status_flags_pkg::BIT_POWERDOWN] = 1'b1;
        end
        // Bank decode from the value about to be held
        daddr_next = {flags_next[status_flags_pkg::BIT_DIR_HIGH],
                      flags_next[status_flags_pkg::BIT_DIR_LOW], direct_low_addr};
        iaddr_next = {flags_next[status_flags_pkg::BIT_IND_BANK], fsr_value};
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers; arithmetic flags have no defined reset, cleared for safety
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_reg  <= {status_flags_pkg::BANK_RESET, status_flags_pkg::CAUSE_RESET,
                           status_flags_pkg::CAUSE_RESET, status_flags_pkg::ARITH_RESET};
            result_reg <= 8'h00;
            daddr_reg  <= 9'h000;
            iaddr_reg  <= 9'h000;
        end else begin
            flags_reg  <= flags_next;
            result_reg <= result_next;
            daddr_reg  <= daddr_next;
            iaddr_reg  <= iaddr_next;
        end
    end

    assign flags_value   = flags_reg;
    assign alu_result    = result_reg;
    assign direct_addr   = daddr_reg;
    assign indirect_addr = iaddr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    cause_ro_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && !cause.power_up && !cause.wdt_clear && !cause.sleep_entry
         && !cause.wdt_timeout) |=> $stable(flags_reg[4:3]))
        else $error("cause bits changed by write");
    clear_file_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.dest_file && hits_flags(instr.dest_addr)
         && instr.op == status_flags_pkg::OP_CLEAR) |=> (flags_reg[7:5] == 3'h0 && flags_reg[2]
         && flags_reg[1:0] == $past(flags_reg[1:0])))
        else $error("clear file wrong");
    add_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_ADD) |=>
         flags_reg[0] == (({1'b0, $past(instr.src_a)} + {1'b0, $past(instr.src_b)}) > 9'h0ff))
        else $error("add carry wrong");
    sub_borrow_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_SUB) |=>
         flags_reg[0] == ($past(instr.src_a) >= $past(instr.src_b)))
        else $error("sub borrow wrong");
    sub_digit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_SUB) |=>
         flags_reg[1] == ($past(instr.src_a[3:0]) >= $past(instr.src_b[3:0])))
        else $error("digit borrow wrong");
    rot_carry_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_ROT_RIGHT) |=>
         flags_reg[0] == $past(instr.src_a[0]))
        else $error("rotate carry wrong");
    zero_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_ADD) |=>
         flags_reg[2] == (8'($past(instr.src_a) + $past(instr.src_b)) == 8'h00))
        else $error("zero flag wrong");
    bank_decode_a: assert property (@(posedge clk) disable iff (sys_rst)
        direct_addr[8:7] == flags_reg[6:5] && indirect_addr[8] == flags_reg[7])
        else $error("bank decode wrong");
    sleep_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
        (cause.sleep_entry && !cause.power_up && !cause.wdt_clear) |=>
         (flags_reg[4] && !flags_reg[3]))
        else $error("sleep flags wrong");
    add_digit_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_ADD) |=>
         flags_reg[1] == (({1'b0, $past(instr.src_a[3:0])} + {1'b0, $past(instr.src_b[3:0])})
         > 5'h0f))
        else $error("add digit carry wrong");
    rot_left_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.op == status_flags_pkg::OP_ROT_LEFT) |=>
         flags_reg[0] == $past(instr.src_a[7]))
        else $error("rotate left carry wrong");
    // A rotate into the register must leave zero and digit carry alone
    arith_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.dest_file
         && instr.dest_addr[6:0] == status_flags_pkg::FLAGS_ADDR_LOW
         && (instr.op == status_flags_pkg::OP_ROT_RIGHT
             || instr.op == status_flags_pkg::OP_ROT_LEFT)) |=>
         flags_reg[2:1] == $past(flags_reg[2:1]))
        else $error("rotate wrote masked flags");
    mirror_write_a: assert property (@(posedge clk) disable iff (sys_rst)
        (instr.valid && instr.dest_file && instr.op == status_flags_pkg::OP_MOVE
         && instr.dest_addr[6:0] == status_flags_pkg::FLAGS_ADDR_LOW) |=>
         (flags_reg[7:5] == $past(instr.src_a[7:5])
          && flags_reg[2:0] == $past(instr.src_a[2:0])))
        else $error("mirror write wrong");
    // No disable here: the reset itself is what is watched
    reset_value_a: assert property (@(posedge clk)
        sys_rst |=> flags_reg[7:3] == 5'h03)
        else $error("reset value wrong");

endmodule

// ===== cpu_exec_model.sv
// Instruction execution model that feeds the flags register
module cpu_exec_model (
    input  wire logic                      clk,
    input  wire logic                      go,
    input  wire logic                      dfile,
    input  wire status_flags_pkg::alu_op_t op,
    input  wire logic [8:0]                addr,
    input  wire logic [7:0]                src_a,
    input  wire logic [7:0]                src_b,
    input  wire logic [7:0]                flags_value,
    output status_flags_pkg::instr_t       instr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial instr = '0;
    ////////////////////////////////////////
    // One instruction per go, launched off the falling edge
    always @(negedge clk) begin
        instr.valid <= go;
        if (go) begin
            instr.op        <= op;
            instr.dest_addr <= addr;
            instr.dest_file <= dfile;
            instr.src_a     <= src_a;
            instr.src_b     <= src_b;
            // Bit set as read-modify-write, so no arithmetic flag moves
            instr.wr_data   <= flags_value | src_b;
        end
    end
endmodule

// ===== cpu_status_flags_register_tb.sv
// Self-checking bench for the flags register
module cpu_status_flags_register_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clk = 1'b0;
    logic                         sys_rst = 1'b1;
    logic                         go = 1'b0;
    logic                         df = 1'b1;
    status_flags_pkg::alu_op_t    op = status_flags_pkg::OP_NONE;
    logic [8:0]                   addr = 9'h000;
    logic [7:0]                   sa = 8'h00;
    logic [7:0]                   sb = 8'h00;
    status_flags_pkg::cause_evt_t cause = '0;
    status_flags_pkg::instr_t     instr;
    logic [7:0]                   flags;
    logic [7:0]                   res;
    logic [8:0]                   daddr;
    logic [8:0]                   iaddr;
    int                           bad_count = 0;
    int                           num_checks = 0;
    int                           cycles = 0;
    logic [3:0]                   evt [5] = '{4'h2, 4'h1, 4'h8, 4'h2, 4'h4};
    logic [1:0]                   cexp [5] = '{2'h2, 2'h0, 2'h3, 2'h2, 2'h3};

    cpu_exec_model part_u (.clk(clk), .go(go), .dfile(df), .op(op), .addr(addr),
        .src_a(sa), .src_b(sb), .flags_value(flags), .instr(instr));
    cpu_status_flags_register dut_u (.clk(clk), .sys_rst(sys_rst), .instr(instr),
        .cause(cause), .direct_low_addr(7'h12), .fsr_value(8'h34), .flags_value(flags),
        .alu_result(res), .direct_addr(daddr), .indirect_addr(iaddr));

    initial forever #5 clk = ~clk;
    ////////////////////////////////////////
    // Hang guard, far above the hundred or so cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Partner takes go on the next falling edge; the design on the rising one
    task automatic run(input status_flags_pkg::alu_op_t o, input logic [8:0] a,
                       input logic [7:0] x, input logic [7:0] y);
        @(negedge clk);
        op <= o; addr <= a; sa <= x; sb <= y; go <= 1'b1;
        @(negedge clk);
        go <= 1'b0;
        @(negedge clk);
    endtask
    task automatic t_arith();
        df <= 1'b0;
        run(status_flags_pkg::OP_ADD, 9'h000, 8'hff, 8'h01);
        chk({1'b0, flags}, 9'h01f);
        chk({1'b0, res}, 9'h000);
        run(status_flags_pkg::OP_ADD, 9'h000, 8'h08, 8'h08);
        chk({1'b0, flags}, 9'h01a);
        run(status_flags_pkg::OP_SUB, 9'h000, 8'h05, 8'h03);
        chk({1'b0, flags}, 9'h01b);
        run(status_flags_pkg::OP_SUB, 9'h000, 8'h03, 8'h05);
        chk({1'b0, flags}, 9'h018);
        chk({1'b0, res}, 9'h0fe);
        run(status_flags_pkg::OP_SUB, 9'h000, 8'h07, 8'h07);
        chk({1'b0, flags}, 9'h01f);
        $display("arith done");
    endtask
    task automatic t_rotate();
        run(status_flags_pkg::OP_ROT_RIGHT, 9'h000, 8'h80, 8'h00);
        chk({8'h00, flags[0]}, 9'h000);
        chk({1'b0, res}, 9'h0c0);
        run(status_flags_pkg::OP_ROT_LEFT, 9'h000, 8'h80, 8'h00);
        chk({8'h00, flags[0]}, 9'h001);
        run(status_flags_pkg::OP_ROT_LEFT, 9'h000, 8'h01, 8'h00);
        chk({8'h00, flags[0]}, 9'h000);
        run(status_flags_pkg::OP_ROT_RIGHT, 9'h000, 8'h01, 8'h00);
        chk({8'h00, flags[0]}, 9'h001);
        $display("rotate done");
    endtask
    // Move through each mirror in turn, walking every bank code
    task automatic t_write();
        logic [1:0] i;
        df <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            i = 2'(k);
            run(status_flags_pkg::OP_MOVE, {i, 7'h03}, {i[0], i, 5'h07}, 8'h00);
            @(negedge clk);
            chk({1'b0, flags}, {1'b0, i[0], i, 5'h1f});
            chk(daddr, {i, 7'h12});
            chk(iaddr, {i[0], 8'h34});
        end
        // Not a mirror address: the register keeps its value
        run(status_flags_pkg::OP_MOVE, 9'h004, 8'h00, 8'h00);
        chk({1'b0, flags}, 9'h0ff);
        $display("write done");
    endtask
    task automatic t_clear();
        run(status_flags_pkg::OP_MOVE, 9'h003, 8'hff, 8'h00);
        chk({1'b0, flags}, 9'h0ff);
        run(status_flags_pkg::OP_CLEAR, 9'h183, 8'h00, 8'h00);
        chk({1'b0, flags}, 9'h01f);
        run(status_flags_pkg::OP_ADD, 9'h083, 8'h00, 8'h00);
        chk({1'b0, flags}, 9'h01c);
        run(status_flags_pkg::OP_BITOP, 9'h103, 8'h00, 8'h80);
        chk({1'b0, flags}, 9'h09c);
        // Rotate into the register: only carry and the bank bits move
        run(status_flags_pkg::OP_ROT_LEFT, 9'h003, 8'h9c, 8'h00);
        chk({1'b0, flags}, 9'h03d);
        run(status_flags_pkg::OP_MOVE, 9'h003, 8'h00, 8'h00);
        chk({1'b0, flags}, 9'h018);
        $display("clear done");
    endtask
    task automatic t_cause();
        for (int k = 0; k < 5; k++) begin
            @(negedge clk);
            cause <= evt[k];
            @(negedge clk);
            cause <= '0;
            @(negedge clk);
            chk({7'h00, flags[4:3]}, {7'h00, cexp[k]});
        end
        $display("cause done");
    endtask
    // Mid-run reset after a full bank write and a sleep entry
    task automatic t_reset();
        run(status_flags_pkg::OP_MOVE, 9'h003, 8'he7, 8'h00);
        cause <= 4'h2;
        @(negedge clk);
        cause <= '0;
        chk({1'b0, flags}, 9'h0f7);
        @(negedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({1'b0, flags}, 9'h018);
        chk(daddr, 9'h012);
        chk(iaddr, 9'h034);
        $display("mid-run reset done");
    endtask

    initial begin
        repeat (12) @(negedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk({1'b0, flags}, 9'h018);
        $display("reset done");
        t_arith();
        t_rotate();
        t_write();
        t_clear();
        t_cause();
        t_reset();
        end_sim();
    end
endmodule
